/* rtl/i2cac_slave.sv */
// Purpose: Write-only two-wire slave that sets amplifier control fields
// Assumes: SCL and SDA are asynchronous pins, sampled by i_ref_clk
// Notes:   SCL at or under 400 kHz gives at least 12 samples per half period
`timescale 1ns/1ns
module i2cac_slave (
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  // Two-wire bus and strap
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda,
  output logic            o_sda_oe,
  input  wire logic       i_addr_sel,
  // Control fields
  output logic [4:0]      o_mono_volume,
  output logic [4:0]      o_left_volume,
  output logic [4:0]      o_right_volume,
  output logic            o_speaker_3d_enable,
  output logic            o_headphone_3d_enable,
  output logic            o_wakeup_speed_bit,
  output logic [3:0]      o_output_mode_code,
  output logic            o_output_mode_reserved
);
  import i2cac_pkg::*;

  logic [2:0]   scl_sync;
  logic [2:0]   sda_sync;
  logic         scl;
  logic         sda;
  logic         scl_q;
  logic         sda_q;
  logic [2:0]   strap_sync;
  logic         strap;
  i2cac_state_t state;
  logic [3:0]   bitcnt;
  logic [7:0]   shreg;
  logic         ack_seen_high;
  logic [7:0]   rx_byte;
  logic         byte_done;
  logic         addr_match_q;

  // Three-stage synchronisers; a level counts once stages 2 and 3 agree
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      scl_sync   <= 3'h7;
      sda_sync   <= 3'h7;
      strap_sync <= 3'h0;
    end else begin
      scl_sync   <= {scl_sync[1:0], i_scl};
      sda_sync   <= {sda_sync[1:0], i_sda};
      strap_sync <= {strap_sync[1:0], i_addr_sel};
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      scl   <= 1'b1;
      sda   <= 1'b1;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      strap <= 1'b0;
    end else begin
      if (scl_sync[1] == scl_sync[2]) scl <= scl_sync[2];
      if (sda_sync[1] == sda_sync[2]) sda <= sda_sync[2];
      scl_q <= scl;
      sda_q <= sda;
      if (strap_sync[1] == strap_sync[2]) strap <= strap_sync[2];
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  assign scl_rise   = scl & ~scl_q;
  // Fall taken as the filter agrees, one clock early, so ack edges land
  // while the pin is still low even with a short low phase
  assign scl_fall   = scl & (scl_sync[1] == scl_sync[2]) & ~scl_sync[2];
  assign start_cond = scl & scl_q & sda_q & ~sda;
  assign stop_cond  = scl & scl_q & ~sda_q & sda;

  logic [7:0] next_shreg;
  logic       addr_match;
  assign next_shreg = {shreg[6:0], sda};
  assign addr_match = (next_shreg[7:2] == I2CAC_ADDR_TOP) &&
                      (next_shreg[1] == strap) && !next_shreg[0];

  // Bus sequencer; start and stop override any bit state
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state    <= I2CAC_IDLE;
      bitcnt   <= 4'h0;
      shreg    <= 8'h00;
      o_sda_oe <= 1'b0;
      rx_byte  <= 8'h00;
      byte_done <= 1'b0;
    end else begin
      byte_done <= 1'b0;
      if (start_cond) begin
        state    <= I2CAC_ADDR;
        bitcnt   <= 4'h0;
        o_sda_oe <= 1'b0;
      end else if (stop_cond) begin
        state    <= I2CAC_IDLE;
        o_sda_oe <= 1'b0;
      end else begin
        unique case (state)
          I2CAC_IDLE, I2CAC_IGNORE: o_sda_oe <= 1'b0;
          I2CAC_ADDR, I2CAC_DATA: begin
            if (scl_rise) begin
              shreg  <= next_shreg;
              bitcnt <= bitcnt + 4'h1;
            end
            // Drive ack only after the 8th bit's falling edge
            if (scl_fall && bitcnt == I2CAC_BITCNT_LAST + 4'h1) begin
              bitcnt <= 4'h0;
              if (state == I2CAC_DATA) begin
                state    <= I2CAC_DACK;
                o_sda_oe <= 1'b1;
                rx_byte  <= shreg;
                byte_done <= 1'b1;
              end else if (addr_match_q) begin
                state    <= I2CAC_AACK;
                o_sda_oe <= 1'b1;
              end else begin
                state <= I2CAC_IGNORE;
              end
            end
          end
          I2CAC_AACK, I2CAC_DACK: begin
            // Release after the falling edge ending the ack pulse
            if (scl_fall && ack_seen_high) begin
              o_sda_oe <= 1'b0;
              state    <= I2CAC_DATA;
            end
          end
          default: state <= I2CAC_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      addr_match_q <= 1'b0;
    end else if (scl_rise && state == I2CAC_ADDR) begin
      addr_match_q <= addr_match;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ack_seen_high <= 1'b0;
    end else if (state != I2CAC_AACK && state != I2CAC_DACK) begin
      ack_seen_high <= 1'b0;
    end else if (scl_rise) begin
      ack_seen_high <= 1'b1;
    end
  end

  // Open-drain: data output is always low, only the enable moves
  always_ff @(posedge i_ref_clk) begin
    o_sda <= 1'b0;
  end

  // Field update, one cycle after the byte lands
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_mono_volume         <= I2CAC_VOL_RST;
      o_left_volume         <= I2CAC_VOL_RST;
      o_right_volume        <= I2CAC_VOL_RST;
      o_speaker_3d_enable   <= 1'b0;
      o_headphone_3d_enable <= 1'b0;
      o_wakeup_speed_bit    <= 1'b0;
      o_output_mode_code    <= I2CAC_MODE_RST;
    end else if (byte_done) begin
      unique case (rx_byte[7:6])
        I2CAC_SEL_MONO: o_mono_volume <= rx_byte[4:0];
        I2CAC_SEL_LEFT: begin
          o_left_volume       <= rx_byte[4:0];
          o_speaker_3d_enable <= rx_byte[I2CAC_BIT_3D];
        end
        I2CAC_SEL_RIGHT: begin
          o_right_volume        <= rx_byte[4:0];
          o_headphone_3d_enable <= rx_byte[I2CAC_BIT_3D];
        end
        I2CAC_SEL_MODE: begin
          o_wakeup_speed_bit <= rx_byte[I2CAC_BIT_WAKE];
          o_output_mode_code <= rx_byte[3:0];
        end
      endcase
    end
  end

  // Reserved mode codes flag for the analog side
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_output_mode_reserved <= 1'b0;
    end else begin
      unique case (o_output_mode_code)
        4'h1, 4'h5, 4'h6, 4'hA, 4'hB, 4'hF: o_output_mode_reserved <= 1'b1;
        default: o_output_mode_reserved <= 1'b0;
      endcase
    end
  end

  // Checks
  property p_sda_low_only;
    @(posedge i_ref_clk) disable iff (i_rst) o_sda == 1'b0;
  endproperty
  a_sda_low_only: assert property (p_sda_low_only)
    else $error("slave drove data line high");

  property p_no_drive_idle;
    @(posedge i_ref_clk) disable iff (i_rst)
      (state == I2CAC_IDLE || state == I2CAC_IGNORE) |=> !o_sda_oe ||
      $past(start_cond);
  endproperty
  a_no_drive_idle: assert property (p_no_drive_idle)
    else $error("data line driven outside a matched transfer");

  property p_stop_idle;
    @(posedge i_ref_clk) disable iff (i_rst)
      stop_cond && !start_cond |=> state == I2CAC_IDLE && !o_sda_oe;
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("stop did not return to idle");

  property p_start_addr;
    @(posedge i_ref_clk) disable iff (i_rst)
      start_cond |=> state == I2CAC_ADDR && bitcnt == 4'h0;
  endproperty
  a_start_addr: assert property (p_start_addr)
    else $error("start did not begin address phase");

  property p_ack_hold;
    @(posedge i_ref_clk) disable iff (i_rst)
      (state == I2CAC_AACK || state == I2CAC_DACK) && scl && !start_cond
      && !stop_cond |-> o_sda_oe;
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("acknowledge released while clock high");

  property p_data_ack;
    @(posedge i_ref_clk) disable iff (i_rst)
      byte_done |-> state == I2CAC_DACK && o_sda_oe;
  endproperty
  a_data_ack: assert property (p_data_ack)
    else $error("data byte not acknowledged");

  property p_mono_write;
    @(posedge i_ref_clk) disable iff (i_rst)
      byte_done && rx_byte[7:6] == I2CAC_SEL_MONO |=>
      o_mono_volume == $past(rx_byte[4:0]);
  endproperty
  a_mono_write: assert property (p_mono_write)
    else $error("mono volume not updated");

  property p_left_write;
    @(posedge i_ref_clk) disable iff (i_rst)
      byte_done && rx_byte[7:6] == I2CAC_SEL_LEFT |=>
      o_left_volume == $past(rx_byte[4:0]) &&
      o_speaker_3d_enable == $past(rx_byte[5]);
  endproperty
  a_left_write: assert property (p_left_write)
    else $error("left volume or speaker 3D not updated");

  property p_mode_write;
    @(posedge i_ref_clk) disable iff (i_rst)
      byte_done && rx_byte[7:6] == I2CAC_SEL_MODE |=>
      o_output_mode_code == $past(rx_byte[3:0]) &&
      o_wakeup_speed_bit == $past(rx_byte[5]);
  endproperty
  a_mode_write: assert property (p_mode_write)
    else $error("mode control not updated");

  property p_ignore_stable;
    @(posedge i_ref_clk) disable iff (i_rst)
      state == I2CAC_IGNORE |=> $stable(o_left_volume) &&
      $stable(o_right_volume);
  endproperty
  a_ignore_stable: assert property (p_ignore_stable)
    else $error("register changed after address mismatch");

  c_addr_ack: cover property (@(posedge i_ref_clk) state == I2CAC_AACK);
  c_ignore: cover property (@(posedge i_ref_clk) state == I2CAC_IGNORE);
  c_two_bytes: cover property (@(posedge i_ref_clk)
    byte_done ##[1:400] byte_done);
endmodule : i2cac_slave

/* rtl/i2cac_pkg.sv */
// Purpose: Shared constants for the two-wire audio control slave
// Assumes: 10 MHz reference clock
// Notes:   Byte routing codes sit in the top two data bits
package i2cac_pkg;
  localparam int          I2CAC_CLK_HZ       = 10_000_000;
  localparam int          I2CAC_SCL_MAX_HZ   = 400_000;
  localparam int          I2CAC_SYNC_STAGES  = 3;
  localparam logic [6:0]  I2CAC_ADDR_HI      = 7'h7C >> 1;
  localparam logic [5:0]  I2CAC_ADDR_TOP     = 6'h3E;
  localparam logic [1:0]  I2CAC_SEL_MONO     = 2'h0;
  localparam logic [1:0]  I2CAC_SEL_LEFT     = 2'h1;
  localparam logic [1:0]  I2CAC_SEL_RIGHT    = 2'h2;
  localparam logic [1:0]  I2CAC_SEL_MODE     = 2'h3;
  localparam int          I2CAC_BIT_3D       = 5;
  localparam int          I2CAC_BIT_WAKE     = 5;
  localparam logic [4:0]  I2CAC_VOL_RST      = 5'h00;
  localparam logic [3:0]  I2CAC_MODE_RST     = 4'h0;
  localparam logic [3:0]  I2CAC_BITCNT_LAST  = 4'h7;
  typedef enum logic [2:0] {
    I2CAC_IDLE, I2CAC_ADDR, I2CAC_AACK, I2CAC_DATA, I2CAC_DACK, I2CAC_IGNORE
  } i2cac_state_t;
endpackage : i2cac_pkg

/* test/i2cac_host.sv */
// Purpose: Two-wire bus master model that writes to the slave
// Assumes: Pull-up resolved in the bench; 800 ns bus clock period
// Notes:   Bus clock stands high between frames, it never runs free
`timescale 1ns/1ns
module i2cac_host (
  // Clock and bus
  input  wire logic i_ref_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  initial begin
    o_scl     = 1'b1;
    o_sda_low = 1'b0;
  end
  task q;
    repeat (2) @(negedge i_ref_clk);
  endtask : q
  task start;
    q();
    o_sda_low = 1'b1;
    q();
    o_scl = 1'b0;
  endtask : start
  task stop;
    q();
    o_sda_low = 1'b1;
    q();
    o_scl = 1'b1;
    q();
    o_sda_low = 1'b0;
    q();
  endtask : stop
  // Data moves mid-low so it is stable for the whole high phase
  task clk_bit(input logic b, output logic s);
    q();
    o_sda_low = ~b;
    q();
    o_scl = 1'b1;
    q();
    q();
    s = i_sda;
    o_scl = 1'b0;
  endtask : clk_bit
  task put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
    clk_bit(1'b1, s);
    ack = ~s;
  endtask : put_byte
endmodule : i2cac_host

/* test/i2cac_slave_test.sv */
// Purpose: Self-checking bench for the two-wire audio control slave
// Assumes: Host model drives the bus; wire level resolved here
// Notes:   All control fields are packed into one vector for compares
`timescale 1ns/1ns
module i2cac_slave_test;
  import i2cac_pkg::*;
  logic        i_ref_clk, i_rst, i_addr_sel, scl, sda_low, sda_oe, sda_o;
  logic        sda, spk, hp, wake, rsv, a;
  logic [4:0]  mono, left, right;
  logic [3:0]  mode;
  logic [23:0] flds;
  int          miscompares, checked;
  // Open drain with pull-up
  assign sda  = ~(sda_low | sda_oe);
  assign flds = {sda_o, mono, left, right, spk, hp, wake, mode, rsv};
  i2cac_slave dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_scl(scl),
    .i_sda(sda), .o_sda(sda_o), .o_sda_oe(sda_oe), .i_addr_sel(i_addr_sel),
    .o_mono_volume(mono), .o_left_volume(left), .o_right_volume(right),
    .o_speaker_3d_enable(spk), .o_headphone_3d_enable(hp),
    .o_wakeup_speed_bit(wake), .o_output_mode_code(mode),
    .o_output_mode_reserved(rsv));
  i2cac_host host (.i_ref_clk(i_ref_clk), .i_sda(sda), .o_scl(scl),
    .o_sda_low(sda_low));
  initial begin
    i_ref_clk = 1'b0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end
  task chk(input string n, input logic [23:0] e, input logic [23:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task final_report;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  task wr(input logic [7:0] b, input logic e);
    host.put_byte(b, a);
    chk("ack", {23'h0, e}, {23'h0, a});
  endtask : wr
  task t_write;
    logic [7:0] w [5];
    w = '{8'h1F, 8'h7B, 8'h97, 8'h77, 8'hED};
    host.start();
    wr(8'hF8, 1'b1);
    foreach (w[i]) wr(w[i], 1'b1);
    host.stop();
    chk("write", {1'b0, 15'h7EF7, 1'b1, 1'b0, 1'b1, 4'hD, 1'b0}, flds);
    $display("t_write done");
  endtask : t_write
  task t_strap;
    i_addr_sel = 1'b1;
    repeat (4) @(negedge i_ref_clk);
    host.start();
    wr(8'hF8, 1'b0);
    wr(8'h00, 1'b0);
    host.stop();
    host.start();
    wr(8'hFB, 1'b0);
    host.stop();
    chk("ignored", {1'b0, 15'h7EF7, 1'b1, 1'b0, 1'b1, 4'hD, 1'b0}, flds);
    host.start();
    wr(8'hFA, 1'b1);
    wr(8'hB7, 1'b1);
    wr(8'h5B, 1'b1);
    host.stop();
    chk("3d", {1'b0, 15'h7F77, 1'b0, 1'b1, 1'b1, 4'hD, 1'b0}, flds);
    $display("t_strap done");
  endtask : t_strap
  task t_modes;
    logic rs;
    host.start();
    wr(8'hFA, 1'b1);
    for (int i = 0; i < 16; i++) begin
      rs = i inside {1, 5, 6, 10, 11, 15};
      wr({4'b1100, 4'(i)}, 1'b1);
      chk("mode", {18'h0, 1'b0, 4'(i), rs}, {18'h0, wake, mode, rsv});
    end
    host.stop();
    $display("t_modes done");
  endtask : t_modes
  task t_partial;
    host.start();
    wr(8'hFA, 1'b1);
    for (int i = 0; i < 4; i++) host.clk_bit(1'b0, a);
    host.stop();
    chk("partial", {1'b0, 15'h7F77, 1'b0, 1'b1, 1'b0, 4'hF, 1'b1}, flds);
    $display("t_partial done");
  endtask : t_partial
  initial begin
    miscompares = 0;
    checked     = 0;
    i_rst       = 1'b1;
    i_addr_sel  = 1'b0;
    repeat (10) @(negedge i_ref_clk);
    i_rst = 1'b0;
    repeat (8) @(negedge i_ref_clk);
    chk("reset", 24'h0, flds);
    $display("t_reset done");
    t_write();
    t_strap();
    t_modes();
    t_partial();
    final_report();
  end
  // Guards against a hung run
  initial begin
    #2_000_000;
    miscompares++;
    final_report();
  end
endmodule : i2cac_slave_test
